// ### rtl/wwdcfg_top.sv
// Window watchdog core: escalation, start-up delay, windows and service handling.
`timescale 1ns/1ps
module wwdcfg_top #(
  parameter int unsigned MS_CYCLES = wwdcfg_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic nvm_load,
  input wire logic [7:0] nvm_cfg,
  input wire logic [7:0] nvm_close,
  input wire logic [7:0] nvm_open,
  input wire logic reset_pin_low_active,
  input wire logic sleep_active,
  output logic wdt_irq,
  output logic wdt_reset,
  output logic wdt_powerdown,
  output logic [1:0] forced_shutdown_field,
  output logic wdt_protected
);
  typedef struct packed {
    wwdcfg_pkg::wwdcfg_state_type st;
    logic [9:0] ms_left;
    logic [13:0] dly_left;
    logic [1:0] stage;
    logic irq;
    logic rst;
    logic pd;
    logic [1:0] shdn;
    logic pin_q;
    logic sleep_q;
    logic [1:0] esc_q;
  } wwdcfg_core_type;

  wwdcfg_core_type s;
  wwdcfg_core_type next_s;
  logic [7:0] cfg;
  logic [7:0] close_code;
  logic [7:0] open_code;
  logic key_wr;
  logic tick;
  logic tick_clr;
  logic expire;
  logic restart;
  logic running;
  logic [1:0] esc;
  logic run_sleep;
  logic [9:0] close_ms;
  logic [9:0] open_ms;
  logic [14:0] delay_ms;

  // ==========================================================================
  // Registers and time base
  wwdcfg_regs u_regs (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .nvm_load(nvm_load),
    .nvm_cfg(nvm_cfg),
    .nvm_close(nvm_close),
    .nvm_open(nvm_open),
    .cfg(cfg),
    .close_code(close_code),
    .open_code(open_code),
    .key_wr(key_wr),
    .wdt_protected(wdt_protected)
  );

  wwdcfg_tick #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clr(tick_clr),
    .tick(tick)
  );

  // ==========================================================================
  // Decoded configuration
  assign esc = cfg[wwdcfg_pkg::ESC_MSB:wwdcfg_pkg::ESC_LSB];
  assign run_sleep = cfg[wwdcfg_pkg::RUN_SLEEP_BIT];
  assign close_ms = wwdcfg_pkg::window_ms(close_code);
  assign open_ms = wwdcfg_pkg::window_ms(open_code);
  // Worst case is eight periods of 1728 ms, which still fits 14 bits.
  assign delay_ms = 15'(4'(cfg[wwdcfg_pkg::DLY_MSB:wwdcfg_pkg::DLY_LSB]) + 4'h1)
    * 15'(11'(close_ms) + 11'(open_ms));
  assign running = !sleep_active || run_sleep;
  assign restart = !reset_pin_low_active || (reset_pin_low_active && !s.pin_q)
    || (esc != s.esc_q) || (!sleep_active && s.sleep_q && !run_sleep);

  // ==========================================================================
  // Watchdog sequencer
  always_comb
  begin
    next_s = s;
    next_s.irq = 1'b0;
    next_s.rst = 1'b0;
    next_s.pd = 1'b0;
    next_s.pin_q = reset_pin_low_active;
    next_s.sleep_q = sleep_active;
    next_s.esc_q = esc;
    tick_clr = 1'b0;
    expire = 1'b0;
    if (esc == wwdcfg_pkg::ESC_OFF)
    begin
      next_s.st = wwdcfg_pkg::ST_IDLE;
      next_s.stage = 2'h0;
      tick_clr = 1'b1;
    end
    else if (restart || s.st == wwdcfg_pkg::ST_IDLE)
    begin
      next_s.st = wwdcfg_pkg::ST_DELAY;
      next_s.dly_left = delay_ms[13:0];
      next_s.stage = 2'h0;
      tick_clr = 1'b1;
    end
    else if (!running)
    begin
      // Holding the tick counter clear keeps a part millisecond from leaking across sleep.
      tick_clr = 1'b1;
    end
    else
    begin
      case (s.st)
        wwdcfg_pkg::ST_DELAY:
        begin
          if (tick)
          begin
            if (s.dly_left <= 14'h0001)
            begin
              next_s.st = wwdcfg_pkg::ST_CLOSE;
              next_s.ms_left = close_ms;
            end
            else
            begin
              next_s.dly_left = s.dly_left - 14'h0001;
            end
          end
        end
        wwdcfg_pkg::ST_CLOSE:
        begin
          if (key_wr)
          begin
            expire = 1'b1;
          end
          else if (tick)
          begin
            if (s.ms_left <= 10'h001)
            begin
              next_s.st = wwdcfg_pkg::ST_OPEN;
              next_s.ms_left = open_ms;
            end
            else
            begin
              next_s.ms_left = s.ms_left - 10'h001;
            end
          end
        end
        wwdcfg_pkg::ST_OPEN:
        begin
          if (key_wr)
          begin
            next_s.st = wwdcfg_pkg::ST_CLOSE;
            next_s.ms_left = close_ms;
            next_s.stage = 2'h0;
            tick_clr = 1'b1;
          end
          else if (tick)
          begin
            if (s.ms_left <= 10'h001)
            begin
              expire = 1'b1;
            end
            else
            begin
              next_s.ms_left = s.ms_left - 10'h001;
            end
          end
        end
        default:
        begin
          next_s.st = wwdcfg_pkg::ST_IDLE;
        end
      endcase
    end
    if (expire)
    begin
      next_s.st = wwdcfg_pkg::ST_CLOSE;
      next_s.ms_left = close_ms;
      tick_clr = 1'b1;
      next_s.stage = (s.stage == 2'h2) ? 2'h2 : s.stage + 2'h1;
      case (esc)
        wwdcfg_pkg::ESC_IRQ_FIRST:
        begin
          next_s.irq = (s.stage == 2'h0);
          next_s.rst = (s.stage == 2'h1);
          next_s.pd = (s.stage == 2'h2);
        end
        wwdcfg_pkg::ESC_RST_FIRST:
        begin
          next_s.rst = (s.stage == 2'h0);
          next_s.pd = (s.stage != 2'h0);
        end
        wwdcfg_pkg::ESC_PD_ONLY:
        begin
          next_s.pd = 1'b1;
        end
        default:
        begin
          next_s.pd = 1'b0;
        end
      endcase
      if (next_s.pd)
      begin
        next_s.shdn = cfg[wwdcfg_pkg::PDM_MSB:wwdcfg_pkg::PDM_LSB];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign wdt_irq = s.irq;
  assign wdt_reset = s.rst;
  assign wdt_powerdown = s.pd;
  assign forced_shutdown_field = s.shdn;

  // ==========================================================================
  // Checks
  sequence s_expire_at(logic [1:0] mode, logic [1:0] stg);
    expire && esc == mode && s.stage == stg;
  endsequence

  property p_off_silent;
    @(posedge ref_clk) disable iff (sys_rst)
      esc == wwdcfg_pkg::ESC_OFF |=> !wdt_irq && !wdt_reset && !wdt_powerdown;
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("Disabled watchdog raised an action.");

  property p_mode1_first;
    @(posedge ref_clk) disable iff (sys_rst)
      s_expire_at(wwdcfg_pkg::ESC_IRQ_FIRST, 2'h0) |=> wdt_irq && !wdt_reset && !wdt_powerdown;
  endproperty
  a_mode1_first: assert property (p_mode1_first) else $error("First expiry did not interrupt.");

  property p_mode1_second;
    @(posedge ref_clk) disable iff (sys_rst)
      s_expire_at(wwdcfg_pkg::ESC_IRQ_FIRST, 2'h1) |=> wdt_reset && !wdt_irq;
  endproperty
  a_mode1_second: assert property (p_mode1_second) else $error("Second expiry did not reset.");

  property p_mode2_first;
    @(posedge ref_clk) disable iff (sys_rst)
      s_expire_at(wwdcfg_pkg::ESC_RST_FIRST, 2'h0) |=> wdt_reset && !wdt_irq && !wdt_powerdown;
  endproperty
  a_mode2_first: assert property (p_mode2_first) else $error("Reset-first mode misbehaved.");

  property p_mode3_pd;
    @(posedge ref_clk) disable iff (sys_rst)
      expire && esc == wwdcfg_pkg::ESC_PD_ONLY |=> wdt_powerdown && !wdt_irq && !wdt_reset;
  endproperty
  a_mode3_pd: assert property (p_mode3_pd) else $error("Power-down mode did not power down.");

  property p_sleep_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      !running && !restart && esc != wwdcfg_pkg::ESC_OFF && s.st != wwdcfg_pkg::ST_IDLE
      |=> $stable(s.ms_left) && $stable(s.st);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("Watchdog ran in sleep.");

  property p_restart_delay;
    @(posedge ref_clk) disable iff (sys_rst)
      restart && esc != wwdcfg_pkg::ESC_OFF |=> s.st == wwdcfg_pkg::ST_DELAY && s.dly_left == $past(delay_ms[13:0]);
  endproperty
  a_restart_delay: assert property (p_restart_delay) else $error("Start-up delay not reloaded.");

  property p_pd_mode_copy;
    @(posedge ref_clk) disable iff (sys_rst)
      wdt_powerdown |-> forced_shutdown_field == $past(cfg[1:0]);
  endproperty
  a_pd_mode_copy: assert property (p_pd_mode_copy) else $error("Shutdown field not copied.");

  property p_close_load;
    @(posedge ref_clk) disable iff (sys_rst)
      s.st == wwdcfg_pkg::ST_CLOSE && $past(s.st) != wwdcfg_pkg::ST_CLOSE
      |-> s.ms_left == wwdcfg_pkg::window_ms($past(close_code));
  endproperty
  a_close_load: assert property (p_close_load) else $error("Close window length wrong.");

  property p_open_load;
    @(posedge ref_clk) disable iff (sys_rst)
      s.st == wwdcfg_pkg::ST_OPEN && $past(s.st) != wwdcfg_pkg::ST_OPEN
      |-> s.ms_left == wwdcfg_pkg::window_ms($past(open_code));
  endproperty
  a_open_load: assert property (p_open_load) else $error("Open window length wrong.");

  property p_early_service;
    @(posedge ref_clk) disable iff (sys_rst)
      s.st == wwdcfg_pkg::ST_CLOSE && key_wr && running && !restart && esc != wwdcfg_pkg::ESC_OFF |-> expire;
  endproperty
  a_early_service: assert property (p_early_service) else $error("Close-window service not flagged.");

  property p_good_service;
    @(posedge ref_clk) disable iff (sys_rst)
      s.st == wwdcfg_pkg::ST_OPEN && key_wr && running && !restart && esc != wwdcfg_pkg::ESC_OFF
      |=> s.st == wwdcfg_pkg::ST_CLOSE && s.stage == 2'h0 && !wdt_irq && !wdt_reset && !wdt_powerdown;
  endproperty
  a_good_service: assert property (p_good_service) else $error("Valid service did not restart period.");
endmodule : wwdcfg_top

// ### rtl/wwdcfg_pkg.sv
// Package of constants, types and the window decoder for the window watchdog.
package wwdcfg_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_CFG = 8'h80;
  localparam logic [7:0] ADDR_CLOSE = 8'h81;
  localparam logic [7:0] ADDR_OPEN = 8'h82;
  localparam logic [7:0] ADDR_KEY = 8'h83;
  localparam logic [7:0] ADDR_PROT1 = 8'hF0;
  localparam logic [7:0] ADDR_PROT2 = 8'hF1;

  // ==========================================================================
  // Field positions and reset values
  localparam int ESC_MSB = 7;
  localparam int ESC_LSB = 6;
  localparam int RUN_SLEEP_BIT = 5;
  localparam int DLY_MSB = 4;
  localparam int DLY_LSB = 2;
  localparam int PDM_MSB = 1;
  localparam int PDM_LSB = 0;
  localparam int PROT_WDT_BIT = 2;
  localparam logic [7:0] PROT_MASK = 8'h7F;
  localparam logic [7:0] REG_RST = 8'h00;

  // ==========================================================================
  // Escalation modes
  localparam logic [1:0] ESC_OFF = 2'h0;
  localparam logic [1:0] ESC_IRQ_FIRST = 2'h1;
  localparam logic [1:0] ESC_RST_FIRST = 2'h2;
  localparam logic [1:0] ESC_PD_ONLY = 2'h3;

  // ==========================================================================
  // Timing
  localparam int MS_NS = 1000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Window code mapping
  localparam logic [7:0] SEG2_CODE = 8'h20;
  localparam logic [7:0] SEG3_CODE = 8'h40;
  localparam logic [9:0] SEG1_BASE_MS = 10'h001;
  localparam logic [9:0] SEG2_BASE_MS = 10'h022;
  localparam logic [9:0] SEG3_BASE_MS = 10'h064;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_CLOSE,
    ST_OPEN
  } wwdcfg_state_type;

  function automatic logic [9:0] window_ms(input logic [7:0] code);
    logic [9:0] ms;
    ms = 10'h000;
    if (code < SEG2_CODE)
    begin
      ms = SEG1_BASE_MS + 10'(code);
    end
    else if (code < SEG3_CODE)
    begin
      ms = SEG2_BASE_MS + (10'(code - SEG2_CODE) << 1);
    end
    else
    begin
      ms = SEG3_BASE_MS + (10'(code - SEG3_CODE) << 2);
    end
    return ms;
  endfunction : window_ms

endpackage : wwdcfg_pkg

// ### rtl/wwdcfg_tick.sv
// Millisecond tick generator for the window watchdog time base.
`timescale 1ns/1ps
module wwdcfg_tick #(
  parameter int unsigned MS_CYCLES = wwdcfg_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clr,
  output logic tick
);
  localparam int CNT_W = $clog2(MS_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(MS_CYCLES - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } wwdcfg_tick_type;

  wwdcfg_tick_type s;
  wwdcfg_tick_type next_s;

  // ==========================================================================
  // Counter
  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (clr)
    begin
      next_s.cnt = '0;
    end
    else if (s.cnt == LAST)
    begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.cnt = s.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule : wwdcfg_tick

// ### rtl/wwdcfg_regs.sv
// Register file of the window watchdog with group protection and power-on load.
`timescale 1ns/1ps
module wwdcfg_regs (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic nvm_load,
  input wire logic [7:0] nvm_cfg,
  input wire logic [7:0] nvm_close,
  input wire logic [7:0] nvm_open,
  output logic [7:0] cfg,
  output logic [7:0] close_code,
  output logic [7:0] open_code,
  output logic key_wr,
  output logic wdt_protected
);
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] close_code;
    logic [7:0] open_code;
    logic [7:0] key;
    logic [7:0] prot1;
    logic [7:0] prot2;
    logic [7:0] rdata;
  } wwdcfg_regs_type;

  wwdcfg_regs_type s;
  wwdcfg_regs_type next_s;
  logic prot;

  // ==========================================================================
  // Decode and write
  assign prot = s.prot1[wwdcfg_pkg::PROT_WDT_BIT] & s.prot2[wwdcfg_pkg::PROT_WDT_BIT];

  always_comb
  begin
    next_s = s;
    if (nvm_load)
    begin
      next_s.cfg = nvm_cfg;
      next_s.close_code = nvm_close;
      next_s.open_code = nvm_open;
    end
    else if (reg_wr && !prot)
    begin
      case (reg_addr)
        wwdcfg_pkg::ADDR_CFG: next_s.cfg = reg_wdata;
        wwdcfg_pkg::ADDR_CLOSE: next_s.close_code = reg_wdata;
        wwdcfg_pkg::ADDR_OPEN: next_s.open_code = reg_wdata;
        default: next_s.cfg = s.cfg;
      endcase
    end
    if (reg_wr)
    begin
      case (reg_addr)
        wwdcfg_pkg::ADDR_KEY: next_s.key = reg_wdata;
        // Protection bits only ever accumulate, so a buggy host cannot unlock.
        wwdcfg_pkg::ADDR_PROT1: next_s.prot1 = (s.prot1 | reg_wdata) & wwdcfg_pkg::PROT_MASK;
        wwdcfg_pkg::ADDR_PROT2: next_s.prot2 = (s.prot2 | reg_wdata) & wwdcfg_pkg::PROT_MASK;
        default: next_s.key = s.key;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        wwdcfg_pkg::ADDR_CFG: next_s.rdata = s.cfg;
        wwdcfg_pkg::ADDR_CLOSE: next_s.rdata = s.close_code;
        wwdcfg_pkg::ADDR_OPEN: next_s.rdata = s.open_code;
        wwdcfg_pkg::ADDR_KEY: next_s.rdata = s.key;
        wwdcfg_pkg::ADDR_PROT1: next_s.rdata = s.prot1;
        wwdcfg_pkg::ADDR_PROT2: next_s.rdata = s.prot2;
        default: next_s.rdata = wwdcfg_pkg::REG_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign cfg = s.cfg;
  assign close_code = s.close_code;
  assign open_code = s.open_code;
  assign key_wr = reg_wr && (reg_addr == wwdcfg_pkg::ADDR_KEY);
  assign wdt_protected = prot;

  // ==========================================================================
  // Checks
  property p_prot_blocks_write;
    @(posedge ref_clk) disable iff (sys_rst)
      prot && reg_wr && !nvm_load && reg_addr == wwdcfg_pkg::ADDR_CFG |=> $stable(s.cfg);
  endproperty
  a_prot_blocks_write: assert property (p_prot_blocks_write) else $error("Protected configuration changed.");

  property p_prot_sticky;
    @(posedge ref_clk) disable iff (sys_rst)
      prot |=> prot;
  endproperty
  a_prot_sticky: assert property (p_prot_sticky) else $error("Protection bit was cleared.");

  property p_nvm_load;
    @(posedge ref_clk) disable iff (sys_rst)
      nvm_load |=> s.cfg == $past(nvm_cfg) && s.open_code == $past(nvm_open);
  endproperty
  a_nvm_load: assert property (p_nvm_load) else $error("Power-on load did not take.");
endmodule : wwdcfg_regs

// ### verif/wwdcfg_host.sv
// Host model that drives the register byte port and services the watchdog.
`timescale 1ns/1ps
module wwdcfg_host (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // ==========================================================================
  // Byte port transfers, launched and released at the falling edge
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    // Released data is inverted so a stale value never looks valid.
    reg_wdata = ~d;
    // One idle edge between transfers keeps a following call from re-driving the strobe in this step.
    @(negedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    @(negedge ref_clk);
  endtask : rd

  // Only the bench decides when a service falls, open or close window.
  task automatic service();
    wr(wwdcfg_pkg::ADDR_KEY, 8'hA5);
  endtask : service
endmodule : wwdcfg_host

// ### verif/window_watchdog_config_bench.sv
// Self-checking bench of the window watchdog core.
`timescale 1ns/1ps
module window_watchdog_config_bench;
  localparam int MSC = 4;
  logic ref_clk, sys_rst, reg_wr, reg_rd, nvm_load, rst_n_pin, sleep_active;
  logic wdt_irq, wdt_reset, wdt_powerdown, wdt_protected;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, nvm_cfg, nvm_close, nvm_open, rv;
  logic [1:0] fsf;
  logic [2:0] ev;
  int n_fail, comparisons, n;

  wwdcfg_top #(.MS_CYCLES(MSC)) u_wwdcfg_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nvm_load(nvm_load),
    .nvm_cfg(nvm_cfg), .nvm_close(nvm_close), .nvm_open(nvm_open), .reset_pin_low_active(rst_n_pin),
    .sleep_active(sleep_active), .wdt_irq(wdt_irq), .wdt_reset(wdt_reset), .wdt_powerdown(wdt_powerdown),
    .forced_shutdown_field(fsf), .wdt_protected(wdt_protected));
  wwdcfg_host u_wwdcfg_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  // ==========================================================================
  // Shared helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // Waits for the first expiry pulse; ev stays zero if none comes within lim cycles.
  task automatic wait_ev(input int lim);
    ev = 3'b000;
    n = 0;
    while (ev === 3'b000 && n < lim)
    begin
      @(negedge ref_clk);
      n++;
      ev = {wdt_powerdown, wdt_reset, wdt_irq};
    end
  endtask : wait_ev

  function automatic int ms_of(input int c);
    if (c < 32)
      return c + 1;
    else if (c < 64)
      return 34 + 2 * (c - 32);
    return 100 + 4 * (c - 64);
  endfunction : ms_of

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    nvm_load = 1'b1;
    @(negedge ref_clk);
    nvm_load = 1'b0;
    u_wwdcfg_host.rd(8'h80, rv); chk(16'(rv), 16'h001A, "cfg load");
    u_wwdcfg_host.rd(8'h81, rv); chk(16'(rv), 16'h003E, "close load");
    u_wwdcfg_host.rd(8'h82, rv); chk(16'(rv), 16'h00C7, "open load");
    u_wwdcfg_host.rd(8'hF5, rv); chk(16'(rv), 16'h0000, "unmapped read");
  endtask : t_regs

  // Three expiries without service; the stage order depends on the escalation field.
  task automatic t_esc(input logic [7:0] c, input logic [2:0] e1, input logic [2:0] e2, input logic [2:0] e3);
    u_wwdcfg_host.wr(8'h81, 8'h00);
    u_wwdcfg_host.wr(8'h82, 8'h00);
    u_wwdcfg_host.wr(8'h80, 8'h00);
    u_wwdcfg_host.wr(8'h80, c);
    wait_ev(200); chk(16'(ev), 16'(e1), "first expiry");
    wait_ev(200); chk(16'(ev), 16'(e2), "second expiry");
    wait_ev(200); chk(16'(ev), 16'(e3), "third expiry");
    @(negedge ref_clk);
    chk(16'(fsf), 16'(c[1:0]), "shutdown field");
  endtask : t_esc

  task automatic t_period(input int c, input int o);
    int t;
    u_wwdcfg_host.wr(8'h81, 8'(c));
    u_wwdcfg_host.wr(8'h82, 8'(o));
    u_wwdcfg_host.wr(8'h80, 8'h00);
    u_wwdcfg_host.wr(8'h80, 8'hC0);
    // The first expiry also carries the start-up delay of one whole period.
    wait_ev(16000); chk(16'(ev), 16'h0004, "first power-down");
    wait_ev(8000); chk(16'(ev), 16'h0004, "second power-down");
    t = (ms_of(c) + ms_of(o)) * MSC - n;
    chk(16'(t >= -2 && t <= 2), 16'h0001, "window period");
  endtask : t_period

  task automatic t_delay();
    int t;
    u_wwdcfg_host.wr(8'h81, 8'h00);
    u_wwdcfg_host.wr(8'h82, 8'h00);
    u_wwdcfg_host.wr(8'h80, 8'h00);
    wait_ev(100); chk(16'(ev), 16'h0000, "disabled");
    u_wwdcfg_host.wr(8'h80, 8'hDC);
    wait_ev(200);
    t = 9 * 2 * MSC - n;
    chk(16'(t >= -3 && t <= 3), 16'h0001, "start-up delay");
  endtask : t_delay

  task automatic t_service();
    u_wwdcfg_host.wr(8'h81, 8'h01);
    u_wwdcfg_host.wr(8'h82, 8'h03);
    u_wwdcfg_host.wr(8'h80, 8'h00);
    u_wwdcfg_host.wr(8'h80, 8'h40);
    wait_ev(400); chk(16'(ev), 16'h0001, "first interrupt");
    for (int i = 0; i < 5; i++)
    begin
      wait_ev(12); chk(16'(ev), 16'h0000, "serviced period");
      u_wwdcfg_host.service();
    end
    wait_ev(60); chk(16'(ev), 16'h0001, "stage restarted");
    // The reset pulse stands while the service write is still in progress, so watch alongside it.
    fork
      u_wwdcfg_host.service();
      wait_ev(3);
    join
    chk(16'(ev), 16'h0002, "close window service");
  endtask : t_service

  task automatic t_sleep_pin();
    u_wwdcfg_host.wr(8'h81, 8'h00);
    u_wwdcfg_host.wr(8'h82, 8'h00);
    u_wwdcfg_host.wr(8'h80, 8'h00);
    sleep_active = 1'b1;
    u_wwdcfg_host.wr(8'h80, 8'hC0);
    wait_ev(150); chk(16'(ev), 16'h0000, "halted in sleep");
    u_wwdcfg_host.wr(8'h80, 8'hE0);
    wait_ev(150); chk(16'(ev), 16'h0004, "runs in sleep");
    sleep_active = 1'b0;
    rst_n_pin = 1'b0;
    wait_ev(150); chk(16'(ev), 16'h0000, "held by reset pin");
    rst_n_pin = 1'b1;
    wait_ev(150); chk(16'(ev), 16'h0004, "after pin release");
  endtask : t_sleep_pin

  task automatic t_protect();
    u_wwdcfg_host.wr(8'h80, 8'h00);
    u_wwdcfg_host.wr(8'hF0, 8'h04);
    chk(16'(wdt_protected), 16'h0000, "one bit only");
    u_wwdcfg_host.wr(8'hF1, 8'h04);
    chk(16'(wdt_protected), 16'h0001, "protected");
    u_wwdcfg_host.wr(8'h80, 8'h11);
    u_wwdcfg_host.wr(8'h82, 8'h22);
    u_wwdcfg_host.rd(8'h80, rv); chk(16'(rv), 16'h0000, "cfg kept");
    u_wwdcfg_host.rd(8'h82, rv); chk(16'(rv), 16'h0000, "open kept");
    u_wwdcfg_host.wr(8'hF0, 8'h00);
    u_wwdcfg_host.rd(8'hF0, rv); chk(16'(rv), 16'h0004, "bit sticks");
    chk(16'(wdt_protected), 16'h0001, "still protected");
  endtask : t_protect

  // ==========================================================================
  // Clock, reset, sequence and watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    n_fail = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    nvm_load = 1'b0;
    nvm_cfg = 8'h1A;
    nvm_close = 8'h3E;
    nvm_open = 8'hC7;
    rst_n_pin = 1'b1;
    sleep_active = 1'b0;
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_regs();
    t_esc(8'h42, 3'b001, 3'b010, 3'b100);
    t_esc(8'h83, 3'b010, 3'b100, 3'b100);
    t_esc(8'hC1, 3'b100, 3'b100, 3'b100);
    t_period(8'h00, 8'h00);
    t_period(8'h1F, 8'h3F);
    t_period(8'h20, 8'h40);
    t_period(8'hFF, 8'hFF);
    t_delay();
    t_service();
    t_sleep_pin();
    t_protect();
    end_of_test();
  end

  initial
  begin
    // Longest path is three full-scale periods plus the shorter scenarios.
    repeat (80000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end
endmodule : window_watchdog_config_bench
